// [hdl/vgaag_regs.sv]
// Behaviour
// [R01] aperture map field places frame buffer window at one of four ranges
// [R02] aperture hits also need pci memory enable and misc output bit 1
// [R03] chain odd/even swaps A0 with a high bit; A0 selects plane pairs
// [R04] software keeps both text/graphics bits consistent
// [R05] color ignore bits include or exclude planes from read mode 1 compare
// [R06] bit mask zero writes latch data; one lets other paths write
// [R07] bit mask applies to every cpu frame buffer write
// [R08] host reads byte, sets bit mask, then writes same byte
// [R09] 3C0h is index read/write and data write; 3C1h is data read
// [R10] each write to 3C0h toggles the index/data flip-flop
// [R11] reading input status one at active emulation port resets flip-flop
// [R12] reads of 3C1h leave the flip-flop unchanged
// [R13] host writes index to 3C0h then reads data at 3C1h
// [R14] video enable clear forces index 00 and opens palette to cpu
// [R15] five bit index selects attribute register 00h to 14h
// [R16] entries give P5..P0, color select gives P7..P6 and optional P5..P4
// [R17] pixel width bit picks palette six bit or two-nibble eight bit output
// [R18] panning compatibility limits panning to upper region in split screen
// [R19] blink bit enables blink via divided vsync, else background intensity
// [R20] ninth pixel copies eighth for line codes when line graphics set
// [R21] display type bit selects color or monochrome attribute decoding
// [R22] border color index shown outside active video
// [R23] plane enable bits gate each plane into the palette lookup
// [R24] flip-flop starts in index state after reset
`timescale 1ns/1ps
`default_nettype none
module vgaag_regs
  import vgaag_pkg::*;
#(
  parameter int BLINK_DIV = BLINK_VSYNC_DIV
) (
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST_N,
  input  wire logic [15:0] I_IO_ADDR,
  input  wire logic        I_IO_WR,
  input  wire logic        I_IO_RD,
  input  wire logic [7:0]  I_IO_WDATA,
  output logic [7:0]       O_IO_RDATA,
  output logic             O_IO_RVALID,
  input  wire logic        I_PCI_MEM_EN,
  input  wire logic        I_MEM_REQ,
  input  wire logic [19:0] I_MEM_ADDR,
  input  wire logic [31:0] I_WR_PLANES,
  input  wire logic [31:0] I_RD_LATCH,
  output logic             O_MEM_HIT,
  output logic [16:0]      O_MEM_OFFSET,
  output logic [3:0]       O_PLANE_SEL,
  output logic [31:0]      O_WR_PLANES,
  output logic [7:0]       O_CMP_RESULT,
  input  wire logic        I_DOT_EN,
  input  wire logic [3:0]  I_PIX_PLANES,
  input  wire logic        I_BORDER,
  input  wire logic        I_TEXT_FG,
  input  wire logic [7:0]  I_ATTR_BYTE,
  input  wire logic [7:0]  I_CHAR_CODE,
  input  wire logic        I_NINTH_PIX,
  input  wire logic        I_LOWER_REGION,
  input  wire logic        I_VSYNC,
  input  wire logic        I_DISP_INACTIVE,
  output logic [7:0]       O_PIX_INDEX,
  output logic             O_PIX_VALID,
  output logic [3:0]       O_PAN_SHIFT,
  output logic             O_PAN_APPLY
);
  vgaag_aff_t  aff_ff;
  logic [4:0]  attr_idx_ff;
  logic        video_en_ff;
  logic [5:0]  pal_ff [16];
  logic [7:0]  amc_ff;
  logic [7:0]  border_ff;
  logic [5:0]  plane_ff;
  logic [3:0]  pan_ff;
  logic [3:0]  csel_ff;
  logic [7:0]  misc_ff;
  logic [3:0]  gfx_idx_ff;
  logic [3:0]  cmp_ff;
  logic [7:0]  gmode_ff;
  logic [3:0]  gmisc_ff;
  logic [3:0]  ignore_ff;
  logic [7:0]  mask_ff;
  logic [7:0]  nxt_rdata;
  logic        wr_attr;
  logic        attr_data_wr;
  logic        wr_gfx;
  logic        rd_status;
  logic [15:0] status_port;
  logic [7:0]  attr_rd;
  logic [7:0]  gfx_rd;
  logic [7:0]  status_rd;
  logic        vsync_d_ff;
  logic [7:0]  blink_cnt_ff;
  logic        blink_ph_ff;
  logic        prev_fg_ff;
  logic        half_ff;
  logic [3:0]  hi_nib_ff;
  logic [3:0]  bg4;
  logic [3:0]  fg4;
  logic        fg_on;
  logic        line_char;
  logic [3:0]  col4;
  logic [5:0]  pal_sel;
  logic [7:0]  idx8;
  logic [1:0]  mux_bits;

  vgaag_cfg_if cfg ();

  assign wr_attr      = I_IO_WR && (I_IO_ADDR == ATTR_WR_PORT);
  assign attr_data_wr = wr_attr && (aff_ff == AFF_DATA);
  assign wr_gfx       = I_IO_WR && (I_IO_ADDR == GFX_DATA_PORT);
  assign status_port  = misc_ff[MISC_COLOR_EMU] ? STAT_COLOR_PORT : STAT_MONO_PORT; // R11
  assign rd_status    = I_IO_RD && (I_IO_ADDR == status_port); // R11

  // index/data flip-flop
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      aff_ff <= AFF_INDEX; // R24
    end else if (wr_attr) begin
      aff_ff <= (aff_ff == AFF_INDEX) ? AFF_DATA : AFF_INDEX; // R10
    end else if (rd_status) begin
      aff_ff <= AFF_INDEX; // R11
    end
  end

  // attribute index register
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      attr_idx_ff <= 5'h00;
      video_en_ff <= 1'b0;
    end else if (wr_attr && aff_ff == AFF_INDEX) begin
      attr_idx_ff <= I_IO_WDATA[4:0]; // R15
      video_en_ff <= I_IO_WDATA[ARX_VIDEO_EN_BIT];
    end
  end

  // palette entries, writable only with video disabled
  for (genvar e = 0; e < 16; e++) begin : g_pal
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
        pal_ff[e] <= 6'h00;
      end else if (attr_data_wr && !video_en_ff && attr_idx_ff == 5'(e)) begin
        pal_ff[e] <= I_IO_WDATA[5:0]; // R14
      end
    end
  end

  // attribute control registers
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      amc_ff    <= RST_BYTE;
      border_ff <= RST_BYTE;
      plane_ff  <= 6'h00;
      pan_ff    <= 4'h0;
      csel_ff   <= 4'h0;
    end else if (attr_data_wr) begin
      unique case (attr_idx_ff) // R15
        ATTR_MODE_IDX:   amc_ff    <= I_IO_WDATA & AMC_RMASK;
        ATTR_BORDER_IDX: border_ff <= I_IO_WDATA;
        ATTR_PLANE_IDX:  plane_ff  <= I_IO_WDATA[5:0];
        ATTR_PAN_IDX:    pan_ff    <= I_IO_WDATA[3:0];
        ATTR_CSEL_IDX:   csel_ff   <= I_IO_WDATA[3:0];
        default: ;
      endcase
    end
  end

  // misc output register
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      misc_ff <= RST_BYTE;
    end else if (I_IO_WR && I_IO_ADDR == MISC_WR_PORT) begin
      misc_ff <= I_IO_WDATA;
    end
  end

  // graphics index and registers
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      gfx_idx_ff <= 4'h0;
      cmp_ff     <= 4'h0;
      gmode_ff   <= RST_BYTE;
      gmisc_ff   <= 4'h0;
      ignore_ff  <= 4'h0;
      mask_ff    <= RST_BYTE;
    end else if (I_IO_WR && I_IO_ADDR == GFX_IDX_PORT) begin
      gfx_idx_ff <= I_IO_WDATA[3:0];
    end else if (wr_gfx) begin
      unique case (gfx_idx_ff)
        GFX_CMP_IDX:  cmp_ff    <= I_IO_WDATA[3:0];
        GFX_MODE_IDX: gmode_ff  <= I_IO_WDATA & GMODE_RMASK;
        GFX_MISC_IDX: gmisc_ff  <= I_IO_WDATA[3:0];
        GFX_IGN_IDX:  ignore_ff <= I_IO_WDATA[3:0];
        GFX_MASK_IDX: mask_ff   <= I_IO_WDATA;
        default: ;
      endcase
    end
  end

  // read data muxes
  always_comb begin
    attr_rd = 8'h00;
    if (attr_idx_ff <= ATTR_PAL_LAST) begin
      attr_rd = video_en_ff ? 8'h00 : {2'b00, pal_pick(attr_idx_ff[3:0])}; // R14
    end else begin
      unique case (attr_idx_ff)
        ATTR_MODE_IDX:   attr_rd = amc_ff;
        ATTR_BORDER_IDX: attr_rd = border_ff;
        ATTR_PLANE_IDX:  attr_rd = {2'b00, plane_ff};
        ATTR_PAN_IDX:    attr_rd = {4'h0, pan_ff};
        ATTR_CSEL_IDX:   attr_rd = {4'h0, csel_ff};
        default:         attr_rd = 8'h00;
      endcase
    end
  end

  always_comb begin
    unique case (gfx_idx_ff)
      GFX_CMP_IDX:  gfx_rd = {4'h0, cmp_ff};
      GFX_MODE_IDX: gfx_rd = gmode_ff;
      GFX_MISC_IDX: gfx_rd = {4'h0, gmisc_ff};
      GFX_IGN_IDX:  gfx_rd = {4'h0, ignore_ff};
      GFX_MASK_IDX: gfx_rd = mask_ff;
      default:      gfx_rd = 8'h00;
    endcase
  end

  always_comb begin
    status_rd = 8'h00;
    status_rd[STAT_MUX_LSB+:2] = mux_bits;
    status_rd[STAT_VSYNC_BIT]  = I_VSYNC;
    status_rd[0]               = I_DISP_INACTIVE;
  end

  always_comb begin
    nxt_rdata = 8'h00;
    if (I_IO_ADDR == ATTR_WR_PORT) begin
      nxt_rdata = {2'b00, video_en_ff, attr_idx_ff}; // R09
    end else if (I_IO_ADDR == ATTR_RD_PORT) begin
      nxt_rdata = attr_rd; // R09 R12
    end else if (I_IO_ADDR == MISC_RD_PORT) begin
      nxt_rdata = misc_ff;
    end else if (I_IO_ADDR == GFX_IDX_PORT) begin
      nxt_rdata = {4'h0, gfx_idx_ff};
    end else if (I_IO_ADDR == GFX_DATA_PORT) begin
      nxt_rdata = gfx_rd;
    end else if (I_IO_ADDR == status_port) begin
      nxt_rdata = status_rd;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_IO_RDATA  <= 8'h00;
      O_IO_RVALID <= 1'b0;
    end else begin
      O_IO_RVALID <= I_IO_RD;
      O_IO_RDATA  <= I_IO_RD ? nxt_rdata : 8'h00;
    end
  end

  function automatic logic [5:0] pal_pick(input logic [3:0] sel);
    pal_pick = pal_ff[sel];
  endfunction : pal_pick

  // graphics datapath configuration
  assign cfg.mem_map      = gmisc_ff[GMC_MAP_LSB+:2];
  assign cfg.chain_oe     = gmisc_ff[GMC_CHAIN];
  assign cfg.mem_en       = I_PCI_MEM_EN && misc_ff[MISC_MEM_EN]; // R02
  assign cfg.read_mode1   = gmode_ff[GMODE_READ1];
  assign cfg.cmp_value    = cmp_ff;
  assign cfg.color_ignore = ignore_ff;
  assign cfg.bit_mask     = mask_ff;

  vgaag_gfx_dpath u_dpath (
    .i_clk        (I_CLK_SYS),
    .i_rst_n      (I_RST_N),
    .cfg          (cfg),
    .i_mem_req    (I_MEM_REQ),
    .i_mem_addr   (I_MEM_ADDR),
    .i_wr_data    (I_WR_PLANES),
    .i_latch      (I_RD_LATCH),
    .o_mem_hit    (O_MEM_HIT),
    .o_mem_offset (O_MEM_OFFSET),
    .o_plane_sel  (O_PLANE_SEL),
    .o_wr_planes  (O_WR_PLANES),
    .o_cmp_result (O_CMP_RESULT)
  );

  // blink phase from divided vsync
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      vsync_d_ff   <= 1'b0;
      blink_cnt_ff <= 8'h00;
      blink_ph_ff  <= 1'b0;
    end else begin
      vsync_d_ff <= I_VSYNC;
      if (I_VSYNC && !vsync_d_ff) begin
        if (blink_cnt_ff == 8'(BLINK_DIV - 1)) begin
          blink_cnt_ff <= 8'h00;
          blink_ph_ff  <= !blink_ph_ff; // R19
        end else begin
          blink_cnt_ff <= blink_cnt_ff + 8'h01;
        end
      end
    end
  end

  // attribute to color nibble
  assign line_char = (I_CHAR_CODE >= LINE_CHAR_LO) && (I_CHAR_CODE <= LINE_CHAR_HI);

  always_comb begin
    if (amc_ff[AMC_MONO]) begin
      bg4 = (I_ATTR_BYTE[6:4] == 3'h7) ? 4'h7 : 4'h0; // R21
      fg4 = (I_ATTR_BYTE[6:4] == 3'h7) ? 4'h0 : {I_ATTR_BYTE[3], 3'h7}; // R21
    end else begin
      bg4 = amc_ff[AMC_BLINK] ? {1'b0, I_ATTR_BYTE[6:4]} : I_ATTR_BYTE[7:4]; // R19
      fg4 = I_ATTR_BYTE[3:0];
    end
    fg_on = I_NINTH_PIX ? (amc_ff[AMC_LINE_GFX] && line_char && prev_fg_ff) : I_TEXT_FG; // R20
    if (amc_ff[AMC_BLINK] && I_ATTR_BYTE[7] && blink_ph_ff) begin
      fg_on = 1'b0; // R19
    end
    if (amc_ff[AMC_GRAPHICS]) begin
      col4 = I_PIX_PLANES ^ {amc_ff[AMC_BLINK] && blink_ph_ff, 3'h0}; // R19
    end else begin
      col4 = fg_on ? fg4 : bg4;
    end
    col4    = col4 & plane_ff[3:0]; // R23
    pal_sel = pal_pick(col4);
    idx8    = {csel_ff[3:2], amc_ff[AMC_P54_SEL] ? csel_ff[1:0] : pal_sel[5:4], pal_sel[3:0]}; // R16
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      prev_fg_ff <= 1'b0;
    end else if (I_DOT_EN && !I_NINTH_PIX) begin
      prev_fg_ff <= I_TEXT_FG;
    end
  end

  // pixel output
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_PIX_INDEX <= 8'h00;
      O_PIX_VALID <= 1'b0;
      half_ff     <= 1'b0;
      hi_nib_ff   <= 4'h0;
    end else begin
      O_PIX_VALID <= 1'b0;
      if (I_DOT_EN) begin
        if (!video_en_ff) begin
          O_PIX_INDEX <= 8'h00; // R14
          O_PIX_VALID <= 1'b1;
          half_ff     <= 1'b0;
        end else if (I_BORDER) begin
          O_PIX_INDEX <= border_ff; // R22
          O_PIX_VALID <= 1'b1;
          half_ff     <= 1'b0;
        end else if (amc_ff[AMC_PIX8]) begin
          half_ff <= !half_ff; // R17
          if (half_ff) begin
            O_PIX_INDEX <= {hi_nib_ff, col4}; // R17
            O_PIX_VALID <= 1'b1;
          end else begin
            hi_nib_ff <= col4;
          end
        end else begin
          O_PIX_INDEX <= idx8; // R16 R17
          O_PIX_VALID <= 1'b1;
          half_ff     <= 1'b0;
        end
      end
    end
  end

  // status mux picks two palette bits
  always_comb begin
    unique case (plane_ff[5:4])
      2'h0: mux_bits = {O_PIX_INDEX[2], O_PIX_INDEX[0]};
      2'h1: mux_bits = {O_PIX_INDEX[5], O_PIX_INDEX[4]};
      2'h2: mux_bits = {O_PIX_INDEX[3], O_PIX_INDEX[1]};
      2'h3: mux_bits = {O_PIX_INDEX[7], O_PIX_INDEX[6]};
    endcase
  end

  // panning controls
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_PAN_SHIFT <= 4'h0;
      O_PAN_APPLY <= 1'b0;
    end else begin
      O_PAN_SHIFT <= pan_ff;
      O_PAN_APPLY <= !(amc_ff[AMC_PAN_COMPAT] && I_LOWER_REGION); // R18
    end
  end

  AST_AFF_TOGGLE: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // R10
    (wr_attr && aff_ff == AFF_INDEX) |=> (aff_ff == AFF_DATA))
    else $error("index write did not arm data state");
  AST_AFF_CLEAR: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // R11
    (rd_status && !wr_attr) |=> (aff_ff == AFF_INDEX))
    else $error("status read did not reset flip-flop");
  AST_AFF_HOLD: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // R12
    (I_IO_RD && I_IO_ADDR == ATTR_RD_PORT && !I_IO_WR) |=> $stable(aff_ff))
    else $error("data port read moved flip-flop");
  AST_INDEX_READ: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // R09
    (I_IO_RD && I_IO_ADDR == ATTR_WR_PORT)
    |=> (O_IO_RVALID && O_IO_RDATA == {2'b00, $past(video_en_ff), $past(attr_idx_ff)}))
    else $error("index read value wrong");
  AST_VIDEO_OFF: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // R14
    (I_DOT_EN && !video_en_ff) |=> (O_PIX_VALID && O_PIX_INDEX == 8'h00))
    else $error("disabled video not index 00");
  AST_BORDER: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // R22
    (I_DOT_EN && video_en_ff && I_BORDER) |=> (O_PIX_INDEX == $past(border_ff)))
    else $error("border index not shown");
  AST_PAN_LOWER: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // R18
    (amc_ff[AMC_PAN_COMPAT] && I_LOWER_REGION) |=> !O_PAN_APPLY)
    else $error("lower region panned in compat mode");
endmodule : vgaag_regs
`default_nettype wire

// [hdl/vgaag_pkg.sv]
package vgaag_pkg;
  // host i/o ports
  localparam logic [15:0] ATTR_WR_PORT    = 16'h03C0;
  localparam logic [15:0] ATTR_RD_PORT    = 16'h03C1;
  localparam logic [15:0] MISC_WR_PORT    = 16'h03C2;
  localparam logic [15:0] MISC_RD_PORT    = 16'h03CC;
  localparam logic [15:0] GFX_IDX_PORT    = 16'h03CE;
  localparam logic [15:0] GFX_DATA_PORT   = 16'h03CF;
  localparam logic [15:0] STAT_MONO_PORT  = 16'h03BA;
  localparam logic [15:0] STAT_COLOR_PORT = 16'h03DA;
  // graphics indexes
  localparam logic [3:0]  GFX_CMP_IDX     = 4'h2;
  localparam logic [3:0]  GFX_MODE_IDX    = 4'h5;
  localparam logic [3:0]  GFX_MISC_IDX    = 4'h6;
  localparam logic [3:0]  GFX_IGN_IDX     = 4'h7;
  localparam logic [3:0]  GFX_MASK_IDX    = 4'h8;
  // attribute indexes
  localparam logic [4:0]  ATTR_PAL_LAST   = 5'h0F;
  localparam logic [4:0]  ATTR_MODE_IDX   = 5'h10;
  localparam logic [4:0]  ATTR_BORDER_IDX = 5'h11;
  localparam logic [4:0]  ATTR_PLANE_IDX  = 5'h12;
  localparam logic [4:0]  ATTR_PAN_IDX    = 5'h13;
  localparam logic [4:0]  ATTR_CSEL_IDX   = 5'h14;
  // field positions
  localparam int ARX_VIDEO_EN_BIT = 5;
  localparam int AMC_P54_SEL      = 7;
  localparam int AMC_PIX8         = 6;
  localparam int AMC_PAN_COMPAT   = 5;
  localparam int AMC_BLINK        = 3;
  localparam int AMC_LINE_GFX     = 2;
  localparam int AMC_MONO         = 1;
  localparam int AMC_GRAPHICS     = 0;
  localparam int GMC_MAP_LSB      = 2;
  localparam int GMC_CHAIN        = 1;
  localparam int GMODE_READ1      = 3;
  localparam int MISC_COLOR_EMU   = 0;
  localparam int MISC_MEM_EN      = 1;
  localparam int STAT_MUX_LSB     = 4;
  localparam int STAT_VSYNC_BIT   = 3;
  // read masks and reset values
  localparam logic [7:0]  PAL_RMASK       = 8'h3F;
  localparam logic [7:0]  AMC_RMASK       = 8'hEF;
  localparam logic [7:0]  PLANE_RMASK     = 8'h3F;
  localparam logic [7:0]  NIB_RMASK       = 8'h0F;
  localparam logic [7:0]  GMODE_RMASK     = 8'h7B;
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  // aperture map codes and window tags
  localparam logic [1:0]  MAP_A0_BF       = 2'h0;
  localparam logic [1:0]  MAP_A0_AF       = 2'h1;
  localparam logic [1:0]  MAP_B0_B7       = 2'h2;
  localparam logic [1:0]  MAP_B8_BF       = 2'h3;
  localparam logic [2:0]  TAG_A0_BF       = 3'h5;
  localparam logic [3:0]  TAG_A0_AF       = 4'hA;
  localparam logic [4:0]  TAG_B0_B7       = 5'h16;
  localparam logic [4:0]  TAG_B8_BF       = 5'h17;
  // line drawing codes
  localparam logic [7:0]  LINE_CHAR_LO    = 8'hB0;
  localparam logic [7:0]  LINE_CHAR_HI    = 8'hDF;
  localparam int          BLINK_VSYNC_DIV = 16;

  typedef enum logic {AFF_INDEX, AFF_DATA} vgaag_aff_t;
endpackage : vgaag_pkg

// [hdl/vgaag_cfg_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface vgaag_cfg_if;
  logic [1:0] mem_map;
  logic       chain_oe;
  logic       mem_en;
  logic       read_mode1;
  logic [3:0] cmp_value;
  logic [3:0] color_ignore;
  logic [7:0] bit_mask;
  modport src (output mem_map, chain_oe, mem_en, read_mode1, cmp_value, color_ignore, bit_mask);
  modport dst (input  mem_map, chain_oe, mem_en, read_mode1, cmp_value, color_ignore, bit_mask);
endinterface : vgaag_cfg_if
`default_nettype wire

// [hdl/vgaag_gfx_dpath.sv]
`timescale 1ns/1ps
`default_nettype none
module vgaag_gfx_dpath
  import vgaag_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  vgaag_cfg_if.dst         cfg,
  input  wire logic        i_mem_req,
  input  wire logic [19:0] i_mem_addr,
  input  wire logic [31:0] i_wr_data,
  input  wire logic [31:0] i_latch,
  output logic             o_mem_hit,
  output logic [16:0]      o_mem_offset,
  output logic [3:0]       o_plane_sel,
  output logic [31:0]      o_wr_planes,
  output logic [7:0]       o_cmp_result
);
  logic        win;
  logic [16:0] off;
  logic [7:0]  nxt_cmp;

  // window decode per map code
  always_comb begin
    unique case (cfg.mem_map)
      MAP_A0_BF: begin
        win = (i_mem_addr[19:17] == TAG_A0_BF); // R01
        off = i_mem_addr[16:0];
      end
      MAP_A0_AF: begin
        win = (i_mem_addr[19:16] == TAG_A0_AF); // R01
        off = {1'b0, i_mem_addr[15:0]};
      end
      MAP_B0_B7: begin
        win = (i_mem_addr[19:15] == TAG_B0_B7); // R01
        off = {2'b00, i_mem_addr[14:0]};
      end
      MAP_B8_BF: begin
        win = (i_mem_addr[19:15] == TAG_B8_BF); // R01
        off = {2'b00, i_mem_addr[14:0]};
      end
    endcase
  end

  // color compare across included planes
  always_comb begin
    nxt_cmp = 8'hFF;
    for (int b = 0; b < 8; b++) begin
      for (int p = 0; p < 4; p++) begin
        if (cfg.color_ignore[p] && (i_latch[p*8+b] != cfg.cmp_value[p])) begin // R05
          nxt_cmp[b] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mem_hit    <= 1'b0;
      o_mem_offset <= 17'h00000;
      o_plane_sel  <= 4'h0;
    end else begin
      o_mem_hit <= i_mem_req && win && cfg.mem_en; // R02
      if (cfg.chain_oe) begin
        o_mem_offset <= {off[0], off[15:1], off[16]}; // R03
        o_plane_sel  <= off[0] ? 4'hA : 4'h5; // R03
      end else begin
        o_mem_offset <= off;
        o_plane_sel  <= 4'hF;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wr_planes  <= 32'h00000000;
      o_cmp_result <= 8'h00;
    end else begin
      for (int p = 0; p < 4; p++) begin
        o_wr_planes[p*8+:8] <= (i_wr_data[p*8+:8] & cfg.bit_mask) |
                               (i_latch[p*8+:8] & ~cfg.bit_mask); // R06 R07
      end
      o_cmp_result <= cfg.read_mode1 ? nxt_cmp : 8'h00; // R05
    end
  end

  AST_MAP_B8: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R01
    (i_mem_req && cfg.mem_en && cfg.mem_map == MAP_B8_BF && i_mem_addr[19:15] == TAG_B8_BF)
    |=> o_mem_hit)
    else $error("b8000 window access not taken");
  AST_MEM_GATE: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R02
    !cfg.mem_en |=> !o_mem_hit)
    else $error("aperture hit while memory disabled");
  AST_CHAIN_ODD: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R03
    (cfg.chain_oe && i_mem_addr[0]) |=> (o_plane_sel == 4'hA))
    else $error("odd address did not pick planes 1 and 3");
  AST_IGNORE_ALL: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R05
    (cfg.read_mode1 && cfg.color_ignore == 4'h0) |=> (o_cmp_result == 8'hFF))
    else $error("excluded planes affected compare");
  AST_MASK_LATCH: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R06
    (cfg.bit_mask == 8'h00) |=> (o_wr_planes == $past(i_latch)))
    else $error("masked bits not taken from latches");
endmodule : vgaag_gfx_dpath
`default_nettype wire

// [dv/vgaag_host.sv]
`timescale 1ns/1ps
`default_nettype none
module vgaag_host (
  input  wire logic        i_clk,
  input  wire logic        i_rvalid,
  input  wire logic [7:0]  i_rdata,
  output logic [15:0]      o_addr,
  output logic             o_wr,
  output logic             o_rd,
  output logic [7:0]       o_wdata
);
  initial begin
    o_addr  = 16'h0000;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_wdata = 8'h00;
  end
  // one byte write, strobe one cycle
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_wdata <= ~d;
  endtask : wr
  // one byte read, strobe one cycle, data sampled after
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    #1;
    d = i_rvalid ? i_rdata : 8'hXX;
  endtask : rd
endmodule : vgaag_host
`default_nettype wire

// [dv/tb_vgaag_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_vgaag_regs;
  import vgaag_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        pci = 1'b0;
  logic [19:0] maddr = 20'h00000;
  logic [31:0] wpl = 32'h0, lat = 32'h0, wpo;
  logic [15:0] a;
  logic        wr, rd, rv, hit;
  logic [7:0]  wd, rdat, d;
  logic [3:0]  psel, pan_sh, pp = 4'h0;
  logic        mreq = 1'b1, dot_en = 1'b0, brd = 1'b0, lower = 1'b0, dinact = 1'b0, pv, pan_ap;
  logic [7:0]  cmpr, pix;
  logic [16:0] offs;
  logic [11:0] exp_hit = 12'hF11;
  int          fail_count = 0, n_tests = 0, cyc = 0;
  vgaag_host u_vgaag_host (.i_clk(clk), .i_rvalid(rv), .i_rdata(rdat), .o_addr(a),
    .o_wr(wr), .o_rd(rd), .o_wdata(wd));
  vgaag_regs u_vgaag_regs (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_IO_ADDR(a), .I_IO_WR(wr),
    .I_IO_RD(rd), .I_IO_WDATA(wd), .O_IO_RDATA(rdat), .O_IO_RVALID(rv), .I_PCI_MEM_EN(pci),
    .I_MEM_REQ(mreq), .I_MEM_ADDR(maddr), .I_WR_PLANES(wpl), .I_RD_LATCH(lat),
    .O_MEM_HIT(hit), .O_MEM_OFFSET(offs), .O_PLANE_SEL(psel), .O_WR_PLANES(wpo),
    .O_CMP_RESULT(cmpr), .I_DOT_EN(dot_en), .I_PIX_PLANES(pp), .I_BORDER(brd),
    .I_TEXT_FG(1'b0), .I_ATTR_BYTE(8'h00), .I_CHAR_CODE(8'h00), .I_NINTH_PIX(1'b0),
    .I_LOWER_REGION(lower), .I_VSYNC(1'b0), .I_DISP_INACTIVE(dinact), .O_PIX_INDEX(pix),
    .O_PIX_VALID(pv), .O_PAN_SHIFT(pan_sh), .O_PAN_APPLY(pan_ap));
  initial forever #4 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  task automatic probe(input logic [19:0] ad);
    @(posedge clk);
    maddr <= ad;
    @(posedge clk);
    #1;
  endtask : probe
  task automatic gw(input logic [3:0] i, input logic [7:0] v);
    u_vgaag_host.wr(GFX_IDX_PORT, {4'h0, i});
    u_vgaag_host.wr(GFX_DATA_PORT, v);
  endtask : gw
  task automatic dot(input logic b);
    @(posedge clk);
    dot_en <= 1'b1;
    brd    <= b;
    @(posedge clk);
    dot_en <= 1'b0;
    #1;
  endtask : dot
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    u_vgaag_host.wr(ATTR_WR_PORT, 8'h10);
    u_vgaag_host.wr(ATTR_WR_PORT, 8'h21);
    u_vgaag_host.rd(ATTR_RD_PORT, d);
    chk("mode", d, 8'h21);
    u_vgaag_host.wr(ATTR_WR_PORT, 8'h11);
    u_vgaag_host.rd(ATTR_RD_PORT, d);
    u_vgaag_host.wr(ATTR_WR_PORT, 8'hA5);
    u_vgaag_host.rd(ATTR_RD_PORT, d);
    chk("border", d, 8'hA5);
    $display("attribute port test done");
    u_vgaag_host.wr(MISC_WR_PORT, 8'h03);
    u_vgaag_host.wr(ATTR_WR_PORT, 8'h12);
    u_vgaag_host.rd(STAT_COLOR_PORT, d);
    u_vgaag_host.wr(ATTR_WR_PORT, 8'h11);
    u_vgaag_host.wr(ATTR_WR_PORT, 8'h3C);
    u_vgaag_host.rd(ATTR_RD_PORT, d);
    chk("border_after_status", d, 8'h3C);
    u_vgaag_host.wr(ATTR_WR_PORT, 8'h03);
    u_vgaag_host.wr(ATTR_WR_PORT, 8'h2A);
    u_vgaag_host.wr(ATTR_WR_PORT, 8'h23);
    u_vgaag_host.rd(ATTR_RD_PORT, d);
    chk("palette_gated", d, 8'h00);
    $display("status and palette test done");
    @(posedge clk) pci <= 1'b1;
    u_vgaag_host.wr(GFX_IDX_PORT, 8'h06);
    for (int m = 0; m < 4; m++) begin
      u_vgaag_host.wr(GFX_DATA_PORT, 8'((m << 2) + 1));
      probe(20'hA0000);
      chk("hit_a0", hit, exp_hit[11-3*m]);
      probe(20'hB0000);
      chk("hit_b0", hit, exp_hit[10-3*m]);
      probe(20'hB8000);
      chk("hit_b8", hit, exp_hit[9-3*m]);
    end
    @(posedge clk) pci <= 1'b0;
    probe(20'hB8000);
    chk("hit_pci_off", hit, 1'b0);
    @(posedge clk) {pci, mreq} <= 2'b10;
    probe(20'hB8000);
    chk("hit_no_req", hit, 1'b0);
    @(posedge clk) mreq <= 1'b1;
    u_vgaag_host.wr(GFX_DATA_PORT, 8'h0F);
    probe(20'hB8001);
    chk("plane_sel", psel, 4'hA);
    chk("offset", offs, 17'h10000);
    @(posedge clk) lat <= 32'h5A5A5A5A;
    u_vgaag_host.wr(GFX_IDX_PORT, 8'h08);
    u_vgaag_host.wr(GFX_DATA_PORT, 8'h0F);
    @(posedge clk) wpl <= 32'hFFFFFFFF;
    @(posedge clk);
    #1;
    chk("masked_write", wpo, 32'h5F5F5F5F);
    gw(GFX_CMP_IDX, 8'h0F);
    gw(GFX_IGN_IDX, 8'h0F);
    gw(GFX_MODE_IDX, 8'h08);
    @(posedge clk);
    #1;
    chk("compare", cmpr, 8'h5A);
    gw(GFX_IGN_IDX, 8'h00);
    @(posedge clk);
    #1;
    chk("compare_none", cmpr, 8'hFF);
    $display("memory path test done");
    @(posedge clk) dinact <= 1'b1;
    u_vgaag_host.rd(STAT_COLOR_PORT, d);
    chk("status", d, 8'h01);
    u_vgaag_host.wr(ATTR_WR_PORT, 8'h32);
    u_vgaag_host.wr(ATTR_WR_PORT, 8'h03);
    u_vgaag_host.wr(ATTR_WR_PORT, 8'h33);
    u_vgaag_host.rd(ATTR_WR_PORT, d);
    chk("index", d, 8'h33);
    u_vgaag_host.wr(ATTR_WR_PORT, 8'h05);
    @(posedge clk) {pp, lower} <= 5'h1F;
    dot(1'b0);
    chk("pixel", pix, 8'h2A);
    chk("pix_valid", pv, 1'b1);
    dot(1'b1);
    chk("border_pix", pix, 8'h3C);
    chk("pan", {pan_sh, pan_ap}, 5'h0A);
    $display("pixel path test done");
    final_report();
  end
endmodule : tb_vgaag_regs
`default_nettype wire
